// *** rtl/smsc_defines.vh ***
// How it works
// - Five address bits arrive MSB first.
// - Address 24 or more enters test mode.
// - Test mode drives channels zero to four.
// - Full address received switches ladder to channel.
// - Sampling continues 1 us after eighth fall.
// - Hold starts with the conversion.
// - Acquisition spans three and a half shift periods plus 1 us.
// - Input outside acquisition window is ignored.
// - Conversion ends within 32 conversion clocks, except with a full FIFO outside test mode.
// - Finished result waits indefinitely for reading, except in test mode.
// - Reading discards result, next conversion follows.
// - Address maps channels, test input, none, test.
// - Capture on rise, drive on fall, eight cycles.
// - Conversion starts 1 us after eighth fall, 26 to 32 clocks.
`ifndef SMSC_DEFINES_VH
`define SMSC_DEFINES_VH
`define SMSC_CLK_PERIOD_NS 10
`define SMSC_SAMPLE_EXT_NS 1000
`define SMSC_SAMPLE_EXT_CYC ((`SMSC_SAMPLE_EXT_NS + `SMSC_CLK_PERIOD_NS - 1) / `SMSC_CLK_PERIOD_NS)
`define SMSC_ADDR_BITS 5
`define SMSC_XFER_BITS 8
`define SMSC_CONV_MIN 26
`define SMSC_CONV_MAX 32
`define SMSC_CONV_DEF 30
`define SMSC_SETTLE_PHI 4
`define SMSC_LAST_CHAN 5'h12
`define SMSC_TEST_INPUT 5'h13
`define SMSC_TEST_MODE_MIN 5'h18
`define SMSC_FIFO_DEPTH 32
`define SMSC_FIFO_AW 5
`endif

// *** rtl/smsc_fifo.v ***
`timescale 1ns/10ps
module smsc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire core_clk,
  input wire rst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire do_push;
  wire do_pop;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign do_push = in_valid && in_ready;
  assign do_pop = out_valid && out_ready;

  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_push)
      begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (do_pop)
      begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (do_push && !do_pop)
      begin
        count <= count + 1'b1;
      end
      else if (do_pop && !do_push)
      begin
        count <= count - 1'b1;
      end
    end
  end

  always @(posedge core_clk)
  begin
    if (do_push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

// *** rtl/smsc_control.v ***
`timescale 1ns/10ps
`include "smsc_defines.vh"
module smsc_control #(
  parameter CONV_PHI = `SMSC_CONV_DEF,
  parameter FIFO_DEPTH = `SMSC_FIFO_DEPTH,
  parameter FIFO_AW = `SMSC_FIFO_AW
) (
  input wire core_clk,
  input wire rst_n,
  input wire shift_clk,
  input wire chip_sel_n,
  input wire serial_address_in,
  input wire conv_clk,
  input wire comparator_high,
  output reg serial_data_out,
  output reg serial_data_oe_n,
  output reg [4:0] mux_select,
  output reg mux_enable,
  output reg ladder_sample,
  output reg ladder_hold,
  output reg [7:0] dac_code,
  output reg test_mode,
  output reg [4:0] test_drive,
  output reg [4:0] test_drive_oe_n,
  output reg conv_busy
);
  localparam ST_IDLE = 2'b00;
  localparam ST_XFER = 2'b01;
  localparam ST_ACQ = 2'b10;
  localparam ST_CONV = 2'b11;

  // Two-stage synchronisers plus one delay stage for edge detection
  reg [1:0] sclk_sync;
  reg [1:0] cs_sync;
  reg [1:0] din_sync;
  reg [1:0] phi_sync;
  reg [1:0] cmp_sync;
  reg sclk_d;
  reg phi_d;

  reg [1:0] state;
  reg [3:0] rise_cnt;
  reg [3:0] fall_cnt;
  reg [4:0] addr_shift;
  reg [7:0] out_shift;
  reg [7:0] ext_cnt;
  reg [5:0] phi_cnt;
  reg [7:0] sar;

  wire sclk_rise = sclk_sync[1] && !sclk_d;
  wire sclk_fall = !sclk_sync[1] && sclk_d;
  wire phi_rise = phi_sync[1] && !phi_d;
  wire cs_low = !cs_sync[1];
  wire [4:0] next_addr = {addr_shift[3:0], din_sync[1]};
  wire [7:0] head_data;
  wire head_valid;
  wire fifo_ready;
  wire fifo_pop = (state == ST_IDLE) && cs_low;
  localparam integer XFER_I = `SMSC_XFER_BITS;
  localparam integer ADDR_I = `SMSC_ADDR_BITS;
  localparam integer EXT_I = `SMSC_SAMPLE_EXT_CYC;
  localparam integer SETTLE_I = `SMSC_SETTLE_PHI;
  wire [3:0] xfer_bits = XFER_I[3:0];
  wire [3:0] addr_bits = ADDR_I[3:0];
  wire [7:0] ext_limit = EXT_I[7:0];
  wire [5:0] conv_limit = CONV_PHI[5:0];
  wire [5:0] sar_start = SETTLE_I[5:0];

  // Channel decode shared by the mux enable and ladder sample outputs
  function chan_valid;
    input [4:0] a;
    begin
      chan_valid = (a <= `SMSC_TEST_INPUT);
    end
  endfunction

  smsc_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(state == ST_CONV && phi_cnt >= conv_limit && !test_mode),
    .in_ready(fifo_ready),
    .in_data(sar),
    .out_valid(head_valid),
    .out_ready(fifo_pop),
    .out_data(head_data)
  );

  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      sclk_sync <= 2'b00;
      cs_sync <= 2'b11;
      din_sync <= 2'b00;
      phi_sync <= 2'b00;
      cmp_sync <= 2'b00;
      sclk_d <= 1'b0;
      phi_d <= 1'b0;
    end
    else
    begin
      sclk_sync <= {sclk_sync[0], shift_clk};
      cs_sync <= {cs_sync[0], chip_sel_n};
      din_sync <= {din_sync[0], serial_address_in};
      phi_sync <= {phi_sync[0], conv_clk};
      cmp_sync <= {cmp_sync[0], comparator_high};
      sclk_d <= sclk_sync[1];
      phi_d <= phi_sync[1];
    end
  end

  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      rise_cnt <= 4'h0;
      fall_cnt <= 4'h0;
      addr_shift <= 5'h00;
      out_shift <= 8'h00;
      ext_cnt <= 8'h00;
      phi_cnt <= 6'h00;
      sar <= 8'h00;
      serial_data_out <= 1'b0;
      serial_data_oe_n <= 1'b1;
      mux_select <= 5'h00;
      mux_enable <= 1'b0;
      ladder_sample <= 1'b0;
      ladder_hold <= 1'b0;
      dac_code <= 8'h00;
      test_mode <= 1'b0;
      test_drive <= 5'h00;
      test_drive_oe_n <= 5'h1f;
      conv_busy <= 1'b0;
    end
    else
    begin
      serial_data_oe_n <= !(cs_low && state == ST_XFER);
      test_drive_oe_n <= test_mode ? 5'h00 : 5'h1f;
      test_drive <= sar[4:0];
      case (state)
        ST_IDLE:
        begin
          ladder_sample <= 1'b0;
          if (cs_low)
          begin
            // Head result is consumed on the exchange start
            out_shift <= head_valid ? head_data : 8'h00;
            serial_data_out <= head_valid ? head_data[7] : 1'b0;
            rise_cnt <= 4'h0;
            fall_cnt <= 4'h0;
            state <= ST_XFER;
          end
        end
        ST_XFER:
        begin
          if (!cs_low)
          begin
            state <= ST_IDLE;
            ladder_sample <= 1'b0;
          end
          else
          begin
            if (sclk_rise && rise_cnt < xfer_bits)
            begin
              rise_cnt <= rise_cnt + 4'h1;
              if (rise_cnt < addr_bits)
              begin
                addr_shift <= next_addr;
              end
              if (rise_cnt == addr_bits - 4'h1)
              begin
                test_mode <= (next_addr >= `SMSC_TEST_MODE_MIN);
                mux_select <= next_addr;
                mux_enable <= chan_valid(next_addr);
                ladder_sample <= chan_valid(next_addr);
              end
            end
            if (sclk_fall && fall_cnt < xfer_bits)
            begin
              fall_cnt <= fall_cnt + 4'h1;
              out_shift <= {out_shift[6:0], 1'b0};
              serial_data_out <= out_shift[6];
              if (fall_cnt == xfer_bits - 4'h1)
              begin
                ext_cnt <= 8'h00;
                state <= ST_ACQ;
              end
            end
          end
        end
        ST_ACQ:
        begin
          // Sampling extends a fixed time past the last falling edge
          if (ext_cnt >= ext_limit - 8'h01)
          begin
            ladder_sample <= 1'b0;
            ladder_hold <= 1'b1;
            conv_busy <= 1'b1;
            phi_cnt <= 6'h00;
            sar <= 8'h00;
            dac_code <= 8'h80;
            state <= ST_CONV;
          end
          else
          begin
            ext_cnt <= ext_cnt + 8'h01;
          end
        end
        default:
        begin
          if (phi_cnt < conv_limit)
          begin
            if (phi_rise)
            begin
              phi_cnt <= phi_cnt + 6'h01;
              if (phi_cnt >= sar_start && phi_cnt < sar_start + 6'h08)
              begin
                // One successive-approximation bit per conversion clock
                sar <= cmp_sync[1] ? dac_code : (dac_code & ~(8'h80 >> (phi_cnt - sar_start)));
                dac_code <= (cmp_sync[1] ? dac_code : (dac_code & ~(8'h80 >> (phi_cnt - sar_start))))
                  | (8'h40 >> (phi_cnt - sar_start));
              end
            end
          end
          else if (fifo_ready || test_mode)
          begin
            ladder_hold <= 1'b0;
            conv_busy <= 1'b0;
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// *** dv/smsc_control_asserts.sv ***
`timescale 1ns/10ps
module smsc_control_asserts (
  input wire core_clk,
  input wire rst_n,
  input wire chip_sel_n,
  input wire serial_data_oe_n,
  input wire [4:0] mux_select,
  input wire mux_enable,
  input wire ladder_sample,
  input wire ladder_hold,
  input wire test_mode,
  input wire [4:0] test_drive_oe_n,
  input wire conv_busy
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  AST_TEST_ADDR: assert property ($rose(test_mode) |-> mux_select[4:3] == 2'b11)
    else $error("test mode on low address");
  AST_TEST_DRIVE: assert property ($rose(test_mode) |-> ##[0:1] test_drive_oe_n == 5'h00)
    else $error("test pins not driven");
  AST_MUX_RANGE: assert property (mux_enable |-> mux_select <= 5'h13)
    else $error("mux enabled for no channel");
  AST_SAMPLE_LEN: assert property ($fell(ladder_sample) |-> $past(ladder_sample, 8))
    else $error("sampling too short");
  AST_HOLD_AFTER: assert property ($fell(ladder_sample) |-> ##[0:1] ladder_hold)
    else $error("no hold after sampling");
  AST_NO_OVERLAP: assert property (!(ladder_sample && ladder_hold))
    else $error("sample and hold together");
  AST_CONV_BOUND: assert property ($rose(conv_busy) |-> ##[1:700] !conv_busy)
    else $error("conversion too long");
  AST_CONV_MIN: assert property ($rose(conv_busy) |=> conv_busy [*8])
    else $error("conversion too short");
  AST_HOLD_FREE: assert property ($fell(conv_busy) |-> !ladder_hold)
    else $error("hold kept after conversion");
  AST_OE_RELEASE: assert property ($rose(chip_sel_n) |-> ##[1:5] serial_data_oe_n)
    else $error("data pin not released");
endmodule
bind smsc_control smsc_control_asserts u_chk (.core_clk, .rst_n, .chip_sel_n, .serial_data_oe_n, .mux_select,
  .mux_enable, .ladder_sample, .ladder_hold, .test_mode, .test_drive_oe_n, .conv_busy);

// *** dv/smsc_host_model.sv ***
`timescale 1ns/10ps
module smsc_host_model (
  output reg shift_clk,
  output reg chip_sel_n,
  output reg serial_address_in,
  input wire serial_data_out,
  input wire serial_data_oe_n
);
  time t8;
  initial
  begin
    shift_clk = 1'b0;
    chip_sel_n = 1'b1;
    serial_address_in = 1'b0;
  end
  // Eight shift periods of 125 ns, clock idle low between frames
  task xfer(input [4:0] addr, output [7:0] res);
    integer i;
    begin
      // Start off the core clock edge
      #3;
      chip_sel_n = 1'b0;
      #100;
      for (i = 0; i < 8; i = i + 1)
      begin
        serial_address_in = (i < 5) ? addr[4 - i] : ~serial_address_in;
        #31.25;
        shift_clk = 1'b1;
        res[7 - i] = serial_data_oe_n ? 1'bx : serial_data_out;
        #62.5;
        shift_clk = 1'b0;
        t8 = $time;
        #31.25;
      end
      #70;
      chip_sel_n = 1'b1;
      serial_address_in = ~serial_address_in;
    end
  endtask
endmodule

// *** dv/tb_serial_adc_mux_sample_control.sv ***
`timescale 1ns/10ps
module tb_serial_adc_mux_sample_control;
  reg core_clk = 1'b0;
  reg rst_n = 1'b0;
  reg conv_clk = 1'b0;
  reg comparator_high = 1'b0;
  reg [7:0] cap = 8'h00;
  reg [7:0] skew = 8'h00;
  reg [7:0] r;
  integer n_fail = 0;
  integer checked = 0;
  integer cyc = 0;
  wire shift_clk, chip_sel_n, serial_address_in, serial_data_out, serial_data_oe_n;
  wire mux_enable, ladder_sample, ladder_hold, test_mode, conv_busy;
  wire [4:0] mux_select, test_drive_oe_n, test_drive;
  wire [7:0] dac_code;
  always #5 core_clk = ~core_clk;
  always #100 conv_clk = ~conv_clk;
  smsc_control dut (.core_clk, .rst_n, .shift_clk, .chip_sel_n, .serial_address_in, .conv_clk, .comparator_high,
    .serial_data_out, .serial_data_oe_n, .mux_select, .mux_enable, .ladder_sample, .ladder_hold, .dac_code,
    .test_mode, .test_drive, .test_drive_oe_n, .conv_busy);
  smsc_host_model host (.shift_clk, .chip_sel_n, .serial_address_in, .serial_data_out, .serial_data_oe_n);
  function [7:0] cv(input [4:0] a);
    cv = 8'ha5 ^ {a, 3'h0};
  endfunction
  // Ladder charge follows the analog input only while sampling
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (ladder_sample && mux_enable)
      cap <= cv(mux_select) ^ skew;
    comparator_high <= cap >= dac_code;
    if (cyc == 30000)
    begin
      n_fail = n_fail + 1;
      final_report;
    end
  end
  task chk(input string n, input [31:0] got, input [31:0] lo, input [31:0] hi);
    begin
      checked = checked + 1;
      if (((got >= lo) && (got <= hi)) !== 1'b1)
      begin
        n_fail = n_fail + 1;
        $display("BAD %s exp %0d..%0d got %0d", n, lo, hi, got);
      end
    end
  endtask
  task xf(input [4:0] a);
    begin
      repeat (5) @(posedge core_clk);
      wait (!ladder_sample && !conv_busy);
      host.xfer(a, r);
      repeat (8) @(posedge core_clk);
    end
  endtask
  // Input disturbed while held must not reach the result
  task conv;
    time t;
    begin
      wait (ladder_hold);
      chk("sample_ext", $time - host.t8, 1000, 1060);
      skew = 8'h3c;
      t = $time;
      wait (!conv_busy);
      chk("conv_time", $time - t, 5200, 6500);
      skew = 8'h00;
    end
  endtask
  task t_addr;
    begin
      xf(5'h05);
      chk("empty_read", r, 0, 0);
      chk("mux_select", mux_select, 5, 5);
      chk("mux_enable", mux_enable, 1, 1);
      conv;
      $display("t_addr done");
    end
  endtask
  task t_hold;
    begin
      repeat (3000) @(posedge core_clk);
      xf(5'h13);
      chk("result", r, cv(5), cv(5));
      chk("test_input", mux_enable, 1, 1);
      conv;
      xf(5'h14);
      chk("result", r, cv(19), cv(19));
      chk("no_channel", mux_enable, 0, 0);
      conv;
      $display("t_hold done");
    end
  endtask
  task t_test;
    begin
      xf(5'h18);
      chk("test_mode", test_mode, 1, 1);
      chk("test_oe", test_drive_oe_n, 0, 0);
      conv;
      chk("test_drive", test_drive, cv(5'h13) & 8'h1f, cv(5'h13) & 8'h1f);
      xf(5'h00);
      chk("after_test", r, 0, 0);
      chk("test_oe", test_drive_oe_n, 5'h1f, 5'h1f);
      conv;
      xf(5'h01);
      chk("result", r, cv(0), cv(0));
      $display("t_test done");
    end
  endtask
  task final_report;
    begin
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial
  begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_addr;
    t_hold;
    t_test;
    final_report;
  end
endmodule
